/* rtl/msx_modbus_slave.sv */
// modbus rtu slave: request checking, fieldbus scaling, normal and exception replies
// Function
// [RULE1] scale factor is ten to the power of the parameter's decimal places
// [RULE2] written word divided by scale gives the stored engineering value
// [RULE3] values travel as integer words, scaled up on send, down on receive
// [RULE4] failed request answers with function code having its top bit set
// [RULE5] one cause byte follows the modified function code
// [RULE6] success answers with unchanged function code and address or data
// [RULE7] cause 01 for unsupported function code or device in fault
// [RULE8] cause 02 for forbidden address or bad start and count combination
// [RULE9] cause 03 for a data field value illegal in request structure
// [RULE10] cause 04 for writing an out-of-range or duplicated value
// [RULE11] cause 05 when password write mismatches the user password parameter
// [RULE12] cause 06 for wrong frame length or crc mismatch
// [RULE13] cause 07 for writing a read-only parameter
// [RULE14] cause 08 for writing a run-locked parameter while running
// [RULE15] cause 09 when access is attempted while still locked
// [RULE16] master should retry or correct its command after an exception
// [RULE17] successful single write echoes the request including crc
// [RULE18] station address 1 to 247 configurable; zero means broadcast
// [RULE19] exception frame: station, modified code, cause, crc low first
// [RULE20] checks run in fixed order; only the first failure reported
`default_nettype none
module msx_modbus_slave (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              rxValid,
    input  wire logic [7:0]        rxByte,
    input  wire logic              frameEnd,
    output logic                   txValid,
    output logic [7:0]             txByte,
    input  wire logic              txReady,
    input  wire logic [7:0]        stationAddr,
    input  wire logic              deviceFault,
    input  wire logic              driveRunning,
    input  wire logic [15:0]       userPassword,
    output logic [15:0]            paramAddr,
    input  wire msx_pkg::msx_attr_t attr,
    input  wire logic [15:0]       rdInt,
    input  wire logic [15:0]       rdFrac,
    output logic                   wrEn,
    output logic [15:0]            wrValue,
    output logic [15:0]            wrFrac
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] msx_crc(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ msx_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : msx_crc

    function automatic logic [15:0] msx_scale(input logic [1:0] e);
        case (e)
            2'h0: return 16'h0001;
            2'h1: return 16'h000A; // [RULE1]
            2'h2: return 16'h0064;
            default: return 16'h03E8;
        endcase
    endfunction : msx_scale

    msx_pkg::msx_st_t stReg;
    msx_pkg::msx_st_t stNext;

    logic [7:0]  fc;
    logic [15:0] start;
    logic [15:0] word;
    logic        bcast;
    logic        locked;
    assign fc     = stReg.rxBuf[1];
    assign start  = {stReg.rxBuf[2], stReg.rxBuf[3]};
    assign word   = {stReg.rxBuf[4], stReg.rxBuf[5]};
    assign bcast  = stReg.rxBuf[0] == msx_pkg::BROADCAST;
    assign locked = (userPassword != 16'h0000) && !stReg.unlocked;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic       exc;
        logic [7:0] cause;
        logic       echo;
        logic       restart;
        logic [3:0] pos;
        logic [7:0] b;
        logic [15:0] sc;
        exc     = 1'b0;
        cause   = 8'h00;
        echo    = 1'b0;
        restart = 1'b0;
        pos     = 4'(msx_pkg::RD_HDR_LEN + {stReg.wIdx, 1'b0});
        b       = 8'h00;
        sc      = msx_scale(attr.scaleExp);
        stNext  = stReg;
        stNext.wrEn = 1'b0;
        case (stReg.state)
            msx_pkg::S_RX: begin
                if (rxValid) begin
                    if (stReg.rxCnt < msx_pkg::REQ_LEN) begin
                        stNext.rxBuf[stReg.rxCnt[2:0]] = rxByte;
                    end
                    // saturate one past full so an overlong frame stays a length error
                    if (stReg.rxCnt <= msx_pkg::REQ_LEN) begin
                        stNext.rxCnt = stReg.rxCnt + 4'h1;
                    end
                    stNext.crc = msx_crc(stReg.crc, rxByte);
                end
                if (frameEnd) begin
                    stNext.state = msx_pkg::S_CHK;
                end
            end
            msx_pkg::S_CHK: begin
                if (stReg.rxCnt == 4'h0 || (!bcast && stReg.rxBuf[0] != stationAddr)) begin
                    restart = 1'b1; // [RULE18]
                end else if (stReg.rxCnt != msx_pkg::REQ_LEN || stReg.crc != 16'h0000) begin
                    exc   = 1'b1; // [RULE12] [RULE20]
                    cause = msx_pkg::EXC_FRAME;
                end else if (deviceFault || (fc != msx_pkg::FC_READ && fc != msx_pkg::FC_WRITE)) begin
                    exc   = 1'b1; // [RULE7]
                    cause = msx_pkg::EXC_FUNC;
                end else if (fc == msx_pkg::FC_READ && bcast) begin
                    restart = 1'b1;
                end else if (fc == msx_pkg::FC_READ
                             && (word == 16'h0000 || word > msx_pkg::MAX_WORDS)) begin
                    exc   = 1'b1; // [RULE9]
                    cause = msx_pkg::EXC_VALUE;
                end else begin
                    stNext.paramAddr = start;
                    stNext.wIdx      = 3'h0;
                    stNext.state     = msx_pkg::S_LOOK;
                end
            end
            msx_pkg::S_LOOK: begin
                if (fc == msx_pkg::FC_READ) begin
                    if (!attr.present) begin
                        exc   = 1'b1; // [RULE8]
                        cause = msx_pkg::EXC_ADDR;
                    end else if (locked) begin
                        exc   = 1'b1; // [RULE15]
                        cause = msx_pkg::EXC_LOCKED;
                    end else begin
                        {stNext.txBuf[pos], stNext.txBuf[pos + 4'h1]} =
                            16'(rdInt * sc + rdFrac); // [RULE3]
                        if (16'(stReg.wIdx) + 16'h0001 == word) begin
                            stNext.txBuf[0] = stationAddr;
                            stNext.txBuf[1] = fc; // [RULE6]
                            stNext.txBuf[2] = {word[6:0], 1'b0};
                            stNext.txLen    = 4'(msx_pkg::RD_HDR_LEN + {word[2:0], 1'b0});
                            stNext.isExc    = 1'b0;
                            stNext.txIdx    = 4'h0;
                            stNext.txCrc    = msx_pkg::CRC_INIT;
                            stNext.state    = msx_pkg::S_SEND;
                        end else begin
                            stNext.wIdx      = stReg.wIdx + 3'h1;
                            stNext.paramAddr = stReg.paramAddr + 16'h0001;
                        end
                    end
                end else if (start == msx_pkg::PWD_ADDR) begin
                    if (word == userPassword) begin
                        stNext.unlocked = 1'b1;
                        echo            = 1'b1;
                    end else begin
                        exc   = 1'b1; // [RULE11]
                        cause = msx_pkg::EXC_PWD;
                    end
                end else if (!attr.present) begin
                    exc   = 1'b1; // [RULE8]
                    cause = msx_pkg::EXC_ADDR;
                end else if (word < attr.minVal || word > attr.maxVal || attr.dupFunc) begin
                    exc   = 1'b1; // [RULE10]
                    cause = msx_pkg::EXC_OPER;
                end else if (attr.readOnly) begin
                    exc   = 1'b1; // [RULE13]
                    cause = msx_pkg::EXC_RDONLY;
                end else if (attr.runLock && driveRunning) begin
                    exc   = 1'b1; // [RULE14]
                    cause = msx_pkg::EXC_RUNNING;
                end else if (locked) begin
                    exc   = 1'b1; // [RULE15]
                    cause = msx_pkg::EXC_LOCKED;
                end else begin
                    stNext.wrEn    = 1'b1;
                    stNext.wrValue = 16'(word / sc); // [RULE2]
                    stNext.wrFrac  = 16'(word % sc);
                    echo           = 1'b1;
                end
            end
            msx_pkg::S_SEND: begin
                if (!stReg.txValid || txReady) begin
                    if (stReg.txIdx == 4'(stReg.txLen + 4'h2)) begin
                        stNext.txValid = 1'b0;
                        restart        = 1'b1;
                    end else begin
                        if (stReg.txIdx < stReg.txLen) begin
                            b = stReg.txBuf[stReg.txIdx];
                            stNext.txCrc = msx_crc(stReg.txCrc, b);
                        end else if (stReg.txIdx == stReg.txLen) begin
                            b = stReg.txCrc[7:0]; // [RULE19]
                        end else begin
                            b = stReg.txCrc[15:8];
                        end
                        stNext.txValid = 1'b1;
                        stNext.txByte  = b;
                        stNext.txIdx   = stReg.txIdx + 4'h1;
                    end
                end
            end
            default: begin
                restart = 1'b1;
            end
        endcase
        // first failure only: each branch above raises at most one cause
        if (exc) begin
            stNext.txBuf[0] = stationAddr; // [RULE19]
            stNext.txBuf[1] = fc | msx_pkg::EXC_BIT; // [RULE4]
            stNext.txBuf[2] = cause; // [RULE5]
            stNext.txLen    = msx_pkg::EXC_LEN;
            stNext.isExc    = 1'b1;
        end
        if (echo) begin
            // same bytes give the same crc, so the reply equals the request
            stNext.txBuf[5:0] = stReg.rxBuf[5:0]; // [RULE17]
            stNext.txLen      = msx_pkg::ECHO_LEN;
            stNext.isExc      = 1'b0;
        end
        if (exc || echo) begin
            stNext.txIdx = 4'h0;
            stNext.txCrc = msx_pkg::CRC_INIT;
            stNext.state = msx_pkg::S_SEND;
        end
        // broadcast writes are carried out but never answered
        if (((exc || echo) && bcast) || restart) begin
            stNext.rxCnt = 4'h0;
            stNext.crc   = msx_pkg::CRC_INIT;
            stNext.state = msx_pkg::S_RX;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stReg <= msx_pkg::ST_RESET;
        end else if (ce) begin
            stReg <= stNext;
        end
    end

    assign txValid   = stReg.txValid;
    assign txByte    = stReg.txByte;
    assign paramAddr = stReg.paramAddr;
    assign wrEn      = stReg.wrEn;
    assign wrValue   = stReg.wrValue;
    assign wrFrac    = stReg.wrFrac;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n || !ce);

    sequence sExcCode;
        stReg.txValid && stReg.isExc && stReg.txIdx == 4'h2;
    endsequence
    sequence sChkOwn;
        stReg.state == msx_pkg::S_CHK && stReg.rxBuf[0] == stationAddr && stReg.rxCnt != 4'h0;
    endsequence
    sequence sFrameOk;
        stReg.rxCnt == msx_pkg::REQ_LEN && stReg.crc == 16'h0000;
    endsequence

    chk_exc_code: assert property (sExcCode |-> stReg.txByte == (fc | msx_pkg::EXC_BIT)) // [RULE4]
        else $error("exception function code lacks top bit");
    chk_exc_length: assert property (stReg.state == msx_pkg::S_SEND && stReg.isExc
                                    |-> stReg.txLen == msx_pkg::EXC_LEN) // [RULE5]
        else $error("exception frame length wrong");
    chk_reply_station: assert property (stReg.txValid && stReg.txIdx == 4'h1
                                        |-> stReg.txByte == stationAddr) // [RULE19]
        else $error("reply does not start with station address");
    chk_frame_cause: assert property (sChkOwn ##0 (stReg.rxCnt != msx_pkg::REQ_LEN)
        |=> stReg.state == msx_pkg::S_SEND && stReg.txBuf[2] == msx_pkg::EXC_FRAME) // [RULE12]
        else $error("bad length not reported as 06");
    chk_fault_cause: assert property (sChkOwn ##0 sFrameOk ##0 deviceFault
        |=> stReg.isExc && stReg.txBuf[2] == msx_pkg::EXC_FUNC) // [RULE7]
        else $error("fault state not reported as 01");
    chk_foreign_frame: assert property (stReg.state == msx_pkg::S_CHK && !bcast
        && stReg.rxBuf[0] != stationAddr |=> stReg.state == msx_pkg::S_RX [*2]) // [RULE18]
        else $error("frame for another station not dropped");
    chk_write_scale: assert property (wrEn |-> 32'(wrValue) * 32'(msx_scale($past(attr.scaleExp)))
                                      + 32'(wrFrac) == 32'(word)) // [RULE2]
        else $error("written value not scaled down");
    chk_write_echo: assert property (stReg.state == msx_pkg::S_SEND && !stReg.isExc
        && fc == msx_pkg::FC_WRITE |-> stReg.txBuf[5:0] == stReg.rxBuf[5:0]) // [RULE17]
        else $error("write reply differs from request");
    chk_pwd_cause: assert property (stReg.state == msx_pkg::S_LOOK && fc == msx_pkg::FC_WRITE
        && start == msx_pkg::PWD_ADDR && word != userPassword && !bcast
        |=> stReg.txBuf[2] == msx_pkg::EXC_PWD) // [RULE11]
        else $error("password mismatch not reported as 05");
    chk_lock_cause: assert property (stReg.state == msx_pkg::S_LOOK && fc == msx_pkg::FC_READ
        && attr.present && locked |=> stReg.txBuf[2] == msx_pkg::EXC_LOCKED) // [RULE15]
        else $error("locked read not reported as 09");
endmodule : msx_modbus_slave
`default_nettype wire

/* rtl/msx_pkg.sv */
// constants and types of the modbus slave response block
`default_nettype none
package msx_pkg;
    // ---------------------------------------------------------------
    // frame codes
    // ---------------------------------------------------------------
    localparam logic [7:0]  FC_READ     = 8'h03;
    localparam logic [7:0]  FC_WRITE    = 8'h06;
    localparam logic [7:0]  EXC_BIT     = 8'h80;
    localparam logic [7:0]  BROADCAST   = 8'h00;
    localparam logic [7:0]  EXC_FUNC    = 8'h01;
    localparam logic [7:0]  EXC_ADDR    = 8'h02;
    localparam logic [7:0]  EXC_VALUE   = 8'h03;
    localparam logic [7:0]  EXC_OPER    = 8'h04;
    localparam logic [7:0]  EXC_PWD     = 8'h05;
    localparam logic [7:0]  EXC_FRAME   = 8'h06;
    localparam logic [7:0]  EXC_RDONLY  = 8'h07;
    localparam logic [7:0]  EXC_RUNNING = 8'h08;
    localparam logic [7:0]  EXC_LOCKED  = 8'h09;
    localparam logic [15:0] PWD_ADDR    = 16'h1F00;
    localparam logic [15:0] CRC_INIT    = 16'hFFFF;
    localparam logic [15:0] CRC_POLY    = 16'hA001;
    // ---------------------------------------------------------------
    // sizes and positions
    // ---------------------------------------------------------------
    localparam logic [3:0]  REQ_LEN     = 4'h8;
    localparam logic [3:0]  EXC_LEN     = 4'h3;
    localparam logic [3:0]  ECHO_LEN    = 4'h6;
    localparam logic [3:0]  RD_HDR_LEN  = 4'h3;
    localparam logic [15:0] MAX_WORDS   = 16'h0004;
    localparam int          TX_BYTES    = 11;

    typedef enum logic [2:0] {
        S_RX   = 3'b000,
        S_CHK  = 3'b001,
        S_LOOK = 3'b010,
        S_SEND = 3'b011
    } msx_state_t;

    // attributes of the parameter at paramAddr, supplied by the store
    typedef struct packed {
        logic        present;
        logic        readOnly;
        logic        runLock;
        logic        dupFunc;
        logic [1:0]  scaleExp;
        logic [15:0] minVal;
        logic [15:0] maxVal;
    } msx_attr_t;

    typedef struct packed {
        msx_state_t               state;
        logic [7:0][7:0]          rxBuf;
        logic [3:0]               rxCnt;
        logic [15:0]              crc;
        logic [2:0]               wIdx;
        logic [TX_BYTES-1:0][7:0] txBuf;
        logic [3:0]               txLen;
        logic [3:0]               txIdx;
        logic [15:0]              txCrc;
        logic                     txValid;
        logic [7:0]               txByte;
        logic                     isExc;
        logic                     unlocked;
        logic [15:0]              paramAddr;
        logic                     wrEn;
        logic [15:0]              wrValue;
        logic [15:0]              wrFrac;
    } msx_st_t;

    localparam msx_st_t ST_RESET = '{state: S_RX, crc: CRC_INIT, txCrc: CRC_INIT,
                                     default: '0};
endpackage : msx_pkg
`default_nettype wire

/* verif/msx_master_model.sv */
// modbus rtu master model: sends request frames and takes reply bytes
`default_nettype none
module msx_master_model (
    input  wire logic       clk,
    output logic            rxValid,
    output logic [7:0]      rxByte,
    output logic            frameEnd,
    input  wire logic       txValid,
    input  wire logic [7:0] txByte,
    output logic            txReady
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rxValid = 1'b0;
        rxByte = 8'hA5;
        frameEnd = 1'b0;
        txReady = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = msx_pkg::CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ msx_pkg::CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction : crc16

    // entered just after a rising edge; bad flips the crc on purpose
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc16(b);
        b.push_back(c[7:0] ^ {7'h00, bad});
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            rxValid <= 1'b1;
            rxByte <= b[i];
            frameEnd <= (i == b.size() - 1);
            @(posedge clk);
        end
        rxValid <= 1'b0;
        frameEnd <= 1'b0;
        // idle line shows no stale byte
        rxByte <= ~rxByte;
    endtask : send

    // stall refusal cycles before each byte: a slow master
    task automatic take(input int n, input int stall, output logic [7:0] q[$]);
        int t;
        q = {};
        for (int i = 0; i < n; i++) begin
            repeat (stall) @(posedge clk);
            if (stall > 0 || i == 0) begin
                txReady <= 1'b1;
            end
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (!(txValid === 1'b1 && txReady === 1'b1) && t < 60);
            q.push_back((txValid === 1'b1 && txReady === 1'b1) ? txByte : 8'hxx);
            if (stall > 0 || i == n - 1) begin
                txReady <= 1'b0;
            end
        end
    endtask : take
endmodule : msx_master_model
`default_nettype wire

/* verif/msx_modbus_slave_tb.sv */
// self-checking bench of the modbus slave response block
`default_nettype none
module msx_modbus_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] msx_bytes_t [$];
    localparam msx_pkg::msx_attr_t okAttr = '{present: 1'b1, scaleExp: 2'd1,
                                              maxVal: 16'h8CA0, default: '0};
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               deviceFault = 1'b0;
    logic               driveRunning = 1'b0;
    logic [7:0]         stationAddr = 8'h01;
    logic [15:0]        userPassword = 16'h0000;
    msx_pkg::msx_attr_t attr = okAttr;
    logic               rxValid, frameEnd, txValid, txReady, wrEn;
    logic [7:0]         rxByte, txByte;
    logic [15:0]        paramAddr, rdInt, rdFrac, wrValue, wrFrac;
    logic [15:0]        lastVal = 16'h0000;
    logic [15:0]        lastFrac = 16'h0000;
    int                 fails = 0;
    int                 checks = 0;
    int                 cycles = 0;
    int                 wrCount = 0;

    always #2 clk = ~clk;
    assign rdInt = paramAddr + 16'h0005;
    assign rdFrac = 16'h0003;

    msx_modbus_slave i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .rxValid(rxValid),
        .rxByte(rxByte), .frameEnd(frameEnd), .txValid(txValid), .txByte(txByte),
        .txReady(txReady), .stationAddr(stationAddr), .deviceFault(deviceFault),
        .driveRunning(driveRunning), .userPassword(userPassword), .paramAddr(paramAddr),
        .attr(attr), .rdInt(rdInt), .rdFrac(rdFrac), .wrEn(wrEn), .wrValue(wrValue),
        .wrFrac(wrFrac));
    msx_master_model i_master (.clk(clk), .rxValid(rxValid), .rxByte(rxByte),
        .frameEnd(frameEnd), .txValid(txValid), .txByte(txByte), .txReady(txReady));

    // ---------------------------------------------------------------
    // write monitor and hang guard
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wrEn === 1'b1) begin
            wrCount <= wrCount + 1;
            lastVal <= wrValue;
            lastFrac <= wrFrac;
        end
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk_frame(input msx_bytes_t q, input msx_bytes_t e);
        check(16'(q.size()), 16'(e.size()));
        foreach (e[i]) begin
            check({8'h00, q[i]}, {8'h00, e[i]});
        end
    endtask : chk_frame

    function automatic msx_bytes_t req(logic [7:0] st, logic [7:0] fc, logic [15:0] a,
                                       logic [15:0] d);
        return '{st, fc, a[15:8], a[7:0], d[15:8], d[7:0]};
    endfunction : req

    function automatic msx_bytes_t crcd(msx_bytes_t b);
        logic [15:0] c;
        c = i_master.crc16(b);
        return {b, c[7:0], c[15:8]};
    endfunction : crcd

    function automatic msx_bytes_t exc(logic [7:0] fc, logic [7:0] cause);
        return crcd('{8'h01, fc | msx_pkg::EXC_BIT, cause});
    endfunction : exc

    // idle edges let the block return to receive
    task automatic xfer(msx_bytes_t r, int n, int stall, logic bad, output msx_bytes_t q);
        i_master.send(r, bad);
        i_master.take(n, stall, q);
        repeat (2) @(posedge clk);
    endtask : xfer

    task automatic quiet(output logic seen);
        seen = 1'b0;
        repeat (30) begin
            @(posedge clk);
            if (txValid !== 1'b0) seen = 1'b1;
        end
    endtask : quiet

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_write;
        msx_bytes_t q;
        msx_pkg::msx_attr_t a;
        logic [15:0] d [3] = '{16'h0032, 16'h0035, 16'h2710};
        logic [15:0] v [3] = '{16'h0005, 16'h0005, 16'h0064};
        logic [15:0] f [3] = '{16'h0000, 16'h0003, 16'h0000};
        int n;
        for (int k = 0; k < 3; k++) begin
            a = okAttr;
            a.scaleExp = (k == 2) ? 2'd2 : 2'd1;
            attr <= a;
            n = wrCount;
            xfer(req(8'h01, msx_pkg::FC_WRITE, 16'h0114, d[k]), 8, k, 1'b0, q);
            chk_frame(q, crcd(req(8'h01, msx_pkg::FC_WRITE, 16'h0114, d[k])));
            check(16'(wrCount - n), 16'h0001);
            check(lastVal, v[k]);
            check(lastFrac, f[k]);
            if (k == 0) check({q[6], q[7]}, 16'h49E7);
        end
        attr <= okAttr;
        $display("test write done");
    endtask : test_write

    task automatic test_read;
        msx_bytes_t q, e;
        logic [15:0] val;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = k ? 4 : 1;
            e = '{8'h01, msx_pkg::FC_READ, 8'(2 * n)};
            for (int w = 0; w < n; w++) begin
                val = (16'h2105 + 16'(w)) * 16'd10 + 16'd3;
                e.push_back(val[15:8]);
                e.push_back(val[7:0]);
            end
            xfer(req(8'h01, msx_pkg::FC_READ, 16'h2100, 16'(n)), 5 + 2 * n, 2 * k, 1'b0, q);
            chk_frame(q, crcd(e));
        end
        $display("test read done");
    endtask : test_read

    task automatic test_exceptions;
        msx_bytes_t q, r;
        msx_pkg::msx_attr_t a;
        logic [7:0] fc, cause;
        logic [15:0] d;
        logic bad;
        int n;
        n = wrCount;
        for (int k = 0; k < 11; k++) begin
            a = okAttr;
            fc = msx_pkg::FC_WRITE;
            d = 16'h0010;
            bad = 1'b0;
            case (k)
                0: begin bad = 1'b1; fc = 8'h10; cause = msx_pkg::EXC_FRAME; end
                1: cause = msx_pkg::EXC_FRAME;
                2: begin fc = 8'h10; cause = msx_pkg::EXC_FUNC; end
                3: begin fc = msx_pkg::FC_READ; d = 16'h0001; cause = msx_pkg::EXC_FUNC; end
                4: begin fc = msx_pkg::FC_READ; d = 16'h0000; cause = msx_pkg::EXC_VALUE; end
                5: begin fc = msx_pkg::FC_READ; d = 16'h0005; cause = msx_pkg::EXC_VALUE; end
                6: begin a.present = 1'b0; cause = msx_pkg::EXC_ADDR; end
                7: begin d = 16'h9000; cause = msx_pkg::EXC_OPER; end
                8: begin a.dupFunc = 1'b1; cause = msx_pkg::EXC_OPER; end
                9: begin a.readOnly = 1'b1; cause = msx_pkg::EXC_RDONLY; end
                default: begin a.runLock = 1'b1; cause = msx_pkg::EXC_RUNNING; end
            endcase
            attr <= a;
            deviceFault <= (k == 3);
            driveRunning <= (k == 10);
            r = req(8'h01, fc, 16'h0114, d);
            if (k == 1) r.pop_back();
            xfer(r, 5, 0, bad, q);
            chk_frame(q, exc(fc, cause));
        end
        check(16'(wrCount - n), 16'h0000);
        attr <= okAttr;
        deviceFault <= 1'b0;
        driveRunning <= 1'b0;
        $display("test exceptions done");
    endtask : test_exceptions

    task automatic test_lock;
        msx_bytes_t q;
        userPassword <= 16'h1234;
        xfer(req(8'h01, msx_pkg::FC_READ, 16'h2100, 16'h0001), 5, 0, 1'b0, q);
        chk_frame(q, exc(msx_pkg::FC_READ, msx_pkg::EXC_LOCKED));
        xfer(req(8'h01, msx_pkg::FC_WRITE, 16'h0114, 16'h0010), 5, 0, 1'b0, q);
        chk_frame(q, exc(msx_pkg::FC_WRITE, msx_pkg::EXC_LOCKED));
        xfer(req(8'h01, msx_pkg::FC_WRITE, msx_pkg::PWD_ADDR, 16'h1111), 5, 0, 1'b0, q);
        chk_frame(q, exc(msx_pkg::FC_WRITE, msx_pkg::EXC_PWD));
        // corrected command after the cause code
        xfer(req(8'h01, msx_pkg::FC_WRITE, msx_pkg::PWD_ADDR, 16'h1234), 8, 1, 1'b0, q);
        chk_frame(q, crcd(req(8'h01, msx_pkg::FC_WRITE, msx_pkg::PWD_ADDR, 16'h1234)));
        xfer(req(8'h01, msx_pkg::FC_READ, 16'h2100, 16'h0001), 7, 0, 1'b0, q);
        chk_frame(q, crcd('{8'h01, 8'h03, 8'h02, 8'h4A, 8'h35}));
        $display("test lock done");
    endtask : test_lock

    task automatic test_station;
        msx_bytes_t q;
        logic seen;
        int n;
        n = wrCount;
        i_master.send(req(8'h02, msx_pkg::FC_WRITE, 16'h0114, 16'h0032), 1'b0);
        quiet(seen);
        check({15'h0000, seen}, 16'h0000);
        i_master.send(req(8'h00, msx_pkg::FC_WRITE, 16'h0114, 16'h0032), 1'b0);
        quiet(seen);
        check({15'h0000, seen}, 16'h0000);
        check(16'(wrCount - n), 16'h0001);
        stationAddr <= 8'hF7;
        xfer(req(8'hF7, msx_pkg::FC_WRITE, 16'h0114, 16'h0032), 8, 0, 1'b0, q);
        chk_frame(q, crcd(req(8'hF7, msx_pkg::FC_WRITE, 16'h0114, 16'h0032)));
        $display("test station done");
    endtask : test_station

    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_write();
        test_read();
        test_exceptions();
        test_lock();
        test_station();
        conclude();
    end
endmodule : msx_modbus_slave_tb
`default_nettype wire
